// *** verilog/nand_read_pkg.sv ***
package nand_read_pkg;

   // ------------------------------------------------------------
   // Read opcodes
   // ------------------------------------------------------------
   localparam logic [7:0] OP_FAST     = 8'h0b;
   localparam logic [7:0] OP_FAST_EXT = 8'h0c;
   localparam logic [7:0] OP_DUAL     = 8'h3b;
   localparam logic [7:0] OP_DUAL_EXT = 8'h3c;
   localparam logic [7:0] OP_QUAD     = 8'h6b;
   localparam logic [7:0] OP_QUAD_EXT = 8'h6c;
   localparam logic [7:0] OP_DUAL_IO  = 8'hbb;

   // ------------------------------------------------------------
   // Phase lengths in link clocks
   // ------------------------------------------------------------
   localparam logic [5:0] CMD_CLKS        = 6'h08;
   localparam logic [5:0] ADDR_CLKS_1     = 6'h10;  // 16-bit column, one bit a clock
   localparam logic [5:0] ADDR_CLKS_2     = 6'h08;  // 16-bit column, two bits a clock
   localparam logic [5:0] DUMMY_STD_BUF   = 6'h08;
   localparam logic [5:0] DUMMY_STD_SEQ   = 6'h20;
   localparam logic [5:0] DUMMY_EXT_BUF   = 6'h18;
   localparam logic [5:0] DUMMY_EXT_SEQ   = 6'h28;
   localparam logic [5:0] DUMMY_DIO_BUF   = 6'h04;
   localparam logic [5:0] DUMMY_DIO_SEQ   = 6'h10;

   // ------------------------------------------------------------
   // Data buffer and array geometry
   // ------------------------------------------------------------
   localparam int         COL_W     = 12;
   localparam int         PAGE_W    = 24;
   localparam logic [11:0] BUF_LAST = 12'h87f;     // last byte of the data buffer
   localparam logic [7:0] BYTE_FILL = 8'hff;       // sent when the FIFO runs dry

   // ------------------------------------------------------------
   // FIFO shape
   // ------------------------------------------------------------
   localparam int FIFO_W     = 8;
   localparam int FIFO_DEPTH = 8;
   localparam int LVL_W      = 4;

   // ------------------------------------------------------------
   // Lane widths
   // ------------------------------------------------------------
   localparam logic [1:0] LANE_1 = 2'h0;
   localparam logic [1:0] LANE_2 = 2'h1;
   localparam logic [1:0] LANE_4 = 2'h2;

   // ------------------------------------------------------------
   // Sequencer states, Gray along the read path
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_IDLE   = 3'h0,
      ST_CMD    = 3'h1,
      ST_ADDR   = 3'h3,
      ST_DUMMY  = 3'h2,
      ST_DATA   = 3'h6,
      ST_DONE   = 3'h7,
      ST_IGNORE = 3'h5
   } state_e;

endpackage

// *** verilog/byte_fifo.sv ***
`timescale 1ns/1ps

// Synchronous FIFO, DEPTH must be a power of two
module byte_fifo
#(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
)
(
   // Clock and reset
   input  wire logic                     clk,
   input  wire logic                     srst,
   input  wire logic                     clr,
   // Fill side
   input  wire logic                     in_valid,
   output logic                          in_ready,
   input  wire logic [WIDTH-1:0]         in_data,
   // Drain side
   output logic                          out_valid,
   input  wire logic                     out_ready,
   output logic [WIDTH-1:0]              out_data,
   output logic [$clog2(DEPTH):0]        level
);

   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr;
   logic [AW-1:0]    rd_ptr;
   logic [AW:0]      count;
   logic [AW:0]      next_count;
   logic             push;
   logic             pop;

   // Handshakes and occupancy
   assign push      = in_valid && in_ready;
   assign out_valid = (count != '0);
   assign pop       = out_valid && out_ready;
   assign out_data  = mem[rd_ptr];
   assign level     = count;

   // Next occupancy
   always_comb
   begin
      next_count = count;
      if (push && !pop)
         next_count = count + 1'b1;
      else if (pop && !push)
         next_count = count - 1'b1;
   end

   // Storage write
   always_ff @(posedge clk)
   begin
      if (push)
         mem[wr_ptr] <= in_data;
   end

   // Pointers, count and registered ready
   always_ff @(posedge clk)
   begin
      if (srst || clr)
      begin
         wr_ptr   <= '0;
         rd_ptr   <= '0;
         count    <= '0;
         in_ready <= 1'b1;
      end
      else
      begin
         if (push)
            wr_ptr <= wr_ptr + 1'b1;
         if (pop)
            rd_ptr <= rd_ptr + 1'b1;
         count    <= next_count;
         in_ready <= (next_count < (AW+1)'(DEPTH));
      end
   end

endmodule

// *** verilog/serial_nand_fast_read.sv ***
`timescale 1ns/1ps

// Behaviour
// - Extended read: opcode, 16-bit column, then 24 or 40 dummy clocks on one line.
// - Buffer bytes leave on falling link clock edges, most significant bit first.
// - Buffer address steps by one per byte while the host keeps clocking.
// - Chip select high ends the read; the device stops the transfer.
// - Buffer-read mode starts at the column and stops at the last buffer byte.
// - Buffer-read mode floats the outputs after the last buffer byte.
// - Sequential mode starts at buffer byte zero and counts upward.
// - Sequential mode rolls into the next page and runs through the array.
// - Dual output read returns two bits per clock on IO0 and IO1.
// - Extended dual output read returns two bits per clock on IO0 and IO1.
// - Quad output read returns four bits per clock on IO0 to IO3.
// - Extended quad output read returns four bits per clock on IO0 to IO3.
// - Both quad output opcodes are refused while the protect-pin enable is set.
// - Dual I/O read takes column and dummy two bits per clock.
// - Standard read: 16-bit column then 8 or 32 dummy clocks.
module serial_nand_fast_read
(
   // Clock and reset
   input  wire logic                             mclk,
   input  wire logic                             srst,
   // Serial link pins
   input  wire logic                             cs_n,
   input  wire logic                             sclk,
   input  wire logic [3:0]                       io_in,
   output logic      [3:0]                       io_out,
   output logic      [3:0]                       io_oe,
   // Configuration levels
   input  wire logic                             buf_mode,
   input  wire logic                             wp_enable,
   input  wire logic [nand_read_pkg::PAGE_W-1:0] start_page,
   // Buffer fetch requests
   output logic                                  rd_valid,
   input  wire logic                             rd_ready,
   output logic      [nand_read_pkg::PAGE_W-1:0] rd_page,
   output logic      [nand_read_pkg::COL_W-1:0]  rd_col,
   // Buffer fetch answers
   input  wire logic                             rsp_valid,
   output logic                                  rsp_ready,
   input  wire logic [nand_read_pkg::FIFO_W-1:0] rsp_data
);

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------

   // Pin pattern for the top bits of a byte
   function automatic logic [3:0] drive_pins(input logic [7:0] b, input logic [1:0] ln);
      case (ln)
         nand_read_pkg::LANE_1: drive_pins = {2'b00, b[7], 1'b0};
         nand_read_pkg::LANE_2: drive_pins = {2'b00, b[7:6]};
         default:               drive_pins = b[7:4];
      endcase
   endfunction

   // Pins driven for a lane width
   function automatic logic [3:0] oe_mask(input logic [1:0] ln);
      case (ln)
         nand_read_pkg::LANE_1: oe_mask = 4'h2;
         nand_read_pkg::LANE_2: oe_mask = 4'h3;
         default:               oe_mask = 4'hf;
      endcase
   endfunction

   // Byte after one clock's worth of bits has left
   function automatic logic [7:0] shift_out(input logic [7:0] b, input logic [1:0] ln);
      case (ln)
         nand_read_pkg::LANE_1: shift_out = {b[6:0], 1'b0};
         nand_read_pkg::LANE_2: shift_out = {b[5:0], 2'b00};
         default:               shift_out = {b[3:0], 4'h0};
      endcase
   endfunction

   // Clocks per byte minus one
   function automatic logic [2:0] byte_clocks(input logic [1:0] ln);
      case (ln)
         nand_read_pkg::LANE_1: byte_clocks = 3'h7;
         nand_read_pkg::LANE_2: byte_clocks = 3'h3;
         default:               byte_clocks = 3'h1;
      endcase
   endfunction

   // Opcode decode: {accepted, lane width}
   function automatic logic [2:0] decode_op(input logic [7:0] op, input logic wp);
      case (op)
         nand_read_pkg::OP_FAST,
         nand_read_pkg::OP_FAST_EXT: decode_op = {1'b1, nand_read_pkg::LANE_1};
         nand_read_pkg::OP_DUAL,
         nand_read_pkg::OP_DUAL_EXT,
         nand_read_pkg::OP_DUAL_IO:  decode_op = {1'b1, nand_read_pkg::LANE_2};
         nand_read_pkg::OP_QUAD,
         nand_read_pkg::OP_QUAD_EXT: decode_op = {!wp, nand_read_pkg::LANE_4};
         default:                    decode_op = 3'h0;
      endcase
   endfunction

   // Dummy clocks for an opcode and read mode
   function automatic logic [5:0] dummy_clocks(input logic [7:0] op, input logic seq);
      case (op)
         nand_read_pkg::OP_FAST_EXT,
         nand_read_pkg::OP_DUAL_EXT,
         nand_read_pkg::OP_QUAD_EXT:
            dummy_clocks = seq ? nand_read_pkg::DUMMY_EXT_SEQ : nand_read_pkg::DUMMY_EXT_BUF;
         nand_read_pkg::OP_DUAL_IO:
            dummy_clocks = seq ? nand_read_pkg::DUMMY_DIO_SEQ : nand_read_pkg::DUMMY_DIO_BUF;
         default:
            dummy_clocks = seq ? nand_read_pkg::DUMMY_STD_SEQ : nand_read_pkg::DUMMY_STD_BUF;
      endcase
   endfunction

   // ------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------
   nand_read_pkg::state_e           state;
   logic                            cs_m;
   logic                            cs_s;
   logic                            sclk_m;
   logic                            sclk_s;
   logic                            sclk_d;
   logic [3:0]                      io_m;
   logic [3:0]                      io_s;
   logic                            rise;
   logic                            fall;
   logic                            frame_end;
   logic [5:0]                      cnt;
   logic [7:0]                      opcode;
   logic [7:0]                      next_op;
   logic [2:0]                      next_dec;
   logic [15:0]                     col;
   logic [1:0]                      lane;
   logic                            seq_mode;
   logic                            in_range;
   logic                            armed;
   logic                            fetch_on;
   logic [nand_read_pkg::LVL_W-1:0] inflight;
   logic [nand_read_pkg::LVL_W-1:0] next_inflight;
   logic [nand_read_pkg::LVL_W-1:0] stale;
   logic [nand_read_pkg::LVL_W-1:0] fifo_level;
   logic                            room;
   logic                            rd_fire;
   logic                            rsp_fire;
   logic                            f_valid;
   logic                            f_pop;
   logic [7:0]                      f_data;
   logic [7:0]                      f_byte;
   logic [7:0]                      sh;
   logic [2:0]                      bit_cnt;
   logic [11:0]                     out_left;
   logic                            drained;

   // ------------------------------------------------------------
   // Pin synchronisers and link clock edges
   // ------------------------------------------------------------

   // Two flops on every pin before use
   always_ff @(posedge mclk)
   begin
      if (srst)
      begin
         cs_m   <= 1'b1;
         cs_s   <= 1'b1;
         sclk_m <= 1'b0;
         sclk_s <= 1'b0;
         sclk_d <= 1'b0;
         io_m   <= 4'h0;
         io_s   <= 4'h0;
      end
      else
      begin
         cs_m   <= cs_n;
         cs_s   <= cs_m;
         sclk_m <= sclk;
         sclk_s <= sclk_m;
         sclk_d <= sclk_s;
         io_m   <= io_in;
         io_s   <= io_m;
      end
   end

   // Edges only count inside a frame
   assign rise      = !cs_s && sclk_s && !sclk_d;
   assign fall      = !cs_s && !sclk_s && sclk_d;
   assign frame_end = cs_s && (state != nand_read_pkg::ST_IDLE);
   assign next_op   = {opcode[6:0], io_s[0]};
   assign next_dec  = decode_op(next_op, wp_enable);
   assign in_range  = (col <= {4'h0, nand_read_pkg::BUF_LAST});

   // ------------------------------------------------------------
   // Instruction sequencer
   // ------------------------------------------------------------

   // Phase tracking from opcode to data
   always_ff @(posedge mclk)
   begin
      if (srst)
      begin
         state <= nand_read_pkg::ST_IDLE;
         cnt   <= 6'h00;
      end
      else if (cs_s)
         state <= nand_read_pkg::ST_IDLE;
      else
      begin
         case (state)
            nand_read_pkg::ST_IDLE:
            begin
               state <= nand_read_pkg::ST_CMD;
               cnt   <= nand_read_pkg::CMD_CLKS - 6'h01;
            end
            nand_read_pkg::ST_CMD:
               if (rise)
               begin
                  cnt <= cnt - 6'h01;
                  if (cnt == 6'h00)
                  begin
                     if (!next_dec[2])
                        state <= nand_read_pkg::ST_IGNORE;
                     else
                     begin
                        state <= nand_read_pkg::ST_ADDR;
                        cnt   <= (next_op == nand_read_pkg::OP_DUAL_IO) ?
                                 nand_read_pkg::ADDR_CLKS_2 - 6'h01 :
                                 nand_read_pkg::ADDR_CLKS_1 - 6'h01;
                     end
                  end
               end
            nand_read_pkg::ST_ADDR:
               if (rise)
               begin
                  cnt <= cnt - 6'h01;
                  if (cnt == 6'h00)
                  begin
                     state <= nand_read_pkg::ST_DUMMY;
                     cnt   <= dummy_clocks(opcode, seq_mode) - 6'h01;
                  end
               end
            nand_read_pkg::ST_DUMMY:
               if (rise)
               begin
                  cnt <= cnt - 6'h01;
                  if (cnt == 6'h00)
                     state <= nand_read_pkg::ST_DATA;
               end
            nand_read_pkg::ST_DATA:
               if (drained)
                  state <= nand_read_pkg::ST_DONE;
            nand_read_pkg::ST_DONE,
            nand_read_pkg::ST_IGNORE:
               state <= state;
            default:
               state <= nand_read_pkg::ST_IDLE;
         endcase
      end
   end

   // Opcode, column, lane width and mode capture
   always_ff @(posedge mclk)
   begin
      if (srst)
      begin
         opcode   <= 8'h00;
         col      <= 16'h0000;
         lane     <= nand_read_pkg::LANE_1;
         seq_mode <= 1'b0;
      end
      else if (state == nand_read_pkg::ST_IDLE)
      begin
         opcode   <= 8'h00;
         seq_mode <= !buf_mode;
      end
      else if (rise && state == nand_read_pkg::ST_CMD)
      begin
         opcode <= next_op;
         if (cnt == 6'h00)
            lane <= next_dec[1:0];
      end
      else if (rise && state == nand_read_pkg::ST_ADDR)
      begin
         if (opcode == nand_read_pkg::OP_DUAL_IO)
            col <= {col[13:0], io_s[1], io_s[0]};
         else
            col <= {col[14:0], io_s[0]};
      end
   end

   // ------------------------------------------------------------
   // Buffer fetch engine
   // ------------------------------------------------------------
   assign rd_fire  = rd_valid && rd_ready;
   assign rsp_fire = rsp_valid && rsp_ready;
   assign room     = ({1'b0, fifo_level} + {1'b0, inflight}) < 5'(nand_read_pkg::FIFO_DEPTH);

   // Requests, one outstanding issue at a time, bounded by FIFO room
   always_ff @(posedge mclk)
   begin
      if (srst)
      begin
         rd_valid <= 1'b0;
         rd_page  <= '0;
         rd_col   <= '0;
         fetch_on <= 1'b0;
         armed    <= 1'b0;
      end
      else if (cs_s || (state != nand_read_pkg::ST_DUMMY && state != nand_read_pkg::ST_DATA))
      begin
         rd_valid <= 1'b0;
         fetch_on <= 1'b0;
         armed    <= 1'b1;
      end
      else if (armed)
      begin
         armed    <= 1'b0;
         rd_page  <= start_page;
         fetch_on <= seq_mode || in_range;
         rd_col   <= seq_mode ? 12'h000 : col[11:0];
      end
      else if (rd_fire)
      begin
         rd_valid <= 1'b0;
         if (rd_col != nand_read_pkg::BUF_LAST)
            rd_col <= rd_col + 12'h001;
         else if (!seq_mode)
            fetch_on <= 1'b0;
         else
         begin
            rd_col  <= 12'h000;
            rd_page <= rd_page + 1'b1;
         end
      end
      else if (fetch_on && !rd_valid && room)
         rd_valid <= 1'b1;
   end

   // Outstanding and stale answer tracking
   always_comb
   begin
      next_inflight = inflight;
      if (rd_fire && !rsp_fire)
         next_inflight = inflight + 1'b1;
      else if (rsp_fire && !rd_fire)
         next_inflight = inflight - 1'b1;
   end

   // Answers owed to an ended frame are swallowed
   always_ff @(posedge mclk)
   begin
      if (srst)
      begin
         inflight <= '0;
         stale    <= '0;
      end
      else
      begin
         inflight <= next_inflight;
         if (frame_end)
            stale <= next_inflight;
         else if (rsp_fire && stale != '0)
            stale <= stale - 1'b1;
      end
   end

   // Byte FIFO between fetch answers and the shifter
   byte_fifo
   #(
      .WIDTH (nand_read_pkg::FIFO_W),
      .DEPTH (nand_read_pkg::FIFO_DEPTH)
   )
   u_byte_fifo
   (
      .clk       (mclk),
      .srst      (srst),
      .clr       (cs_s),
      .in_valid  (rsp_valid && stale == '0),
      .in_ready  (rsp_ready),
      .in_data   (rsp_data),
      .out_valid (f_valid),
      .out_ready (f_pop),
      .out_data  (f_data),
      .level     (fifo_level)
   );

   // ------------------------------------------------------------
   // Output shifter
   // ------------------------------------------------------------
   assign f_byte = f_valid ? f_data : nand_read_pkg::BYTE_FILL;
   assign f_pop  = (state == nand_read_pkg::ST_DATA) && fall && (bit_cnt == 3'h0) &&
                   (seq_mode || out_left != 12'h000);

   // Data out on falling link clock edges
   always_ff @(posedge mclk)
   begin
      if (srst)
      begin
         io_out   <= 4'h0;
         io_oe    <= 4'h0;
         sh       <= 8'h00;
         bit_cnt  <= 3'h0;
         out_left <= 12'h000;
         drained  <= 1'b0;
      end
      else if (state != nand_read_pkg::ST_DATA || cs_s)
      begin
         io_oe    <= 4'h0;
         bit_cnt  <= 3'h0;
         drained  <= 1'b0;
         out_left <= in_range ? nand_read_pkg::BUF_LAST - col[11:0] + 12'h001 : 12'h000;
      end
      else if (fall)
      begin
         if (bit_cnt != 3'h0)
         begin
            io_out  <= drive_pins(sh, lane);
            sh      <= shift_out(sh, lane);
            bit_cnt <= bit_cnt - 3'h1;
         end
         else if (!seq_mode && out_left == 12'h000)
         begin
            io_oe   <= 4'h0;
            drained <= 1'b1;
         end
         else
         begin
            io_out  <= drive_pins(f_byte, lane);
            io_oe   <= oe_mask(lane);
            sh      <= shift_out(f_byte, lane);
            bit_cnt <= byte_clocks(lane);
            if (!seq_mode)
               out_left <= out_left - 12'h001;
         end
      end
   end

endmodule

// *** tb/link_host.sv ***
`timescale 1ns/1ps

// Host controller at the far end of the serial link
module link_host
(
   // Clock and link pins
   input  wire logic       mclk,
   output logic            cs_n,
   output logic            sclk,
   output logic [3:0]      drv,
   input  wire logic [3:0] io_out,
   input  wire logic [3:0] io_oe
);
   logic [7:0] rx [16];
   logic [3:0] oe_any;
   logic [3:0] oe_last;
   logic       released = 1'b1;

   // Idle levels, clock stands low between frames
   initial
   begin
      cs_n = 1'b1;
      sclk = 1'b0;
      drv  = 4'h0;
   end

   // Released lines toggle every cycle so stale values never pass
   always @(posedge mclk)
   begin
      if (released)
         drv <= ~drv;
   end

   // One link clock: low half, sample, high half
   task automatic tick(input logic [3:0] d, output logic [3:0] q);
      if (!released)
         drv <= d;
      sclk <= 1'b0;
      repeat (8) @(posedge mclk);
      q       = io_out;
      oe_last = io_oe;
      oe_any  = oe_any | io_oe;
      sclk <= 1'b1;
      repeat (8) @(posedge mclk);
   endtask

   // Whole read frame; bytes land in rx modulo 16
   task automatic frame(input logic [7:0] op, input logic [15:0] col, input int dum, input int n,
                        input int ln, input bit dio);
      logic [3:0] q;
      logic [7:0] b;
      released = 1'b0;
      oe_any   = 4'h0;
      @(posedge mclk);
      cs_n <= 1'b0;
      repeat (4) @(posedge mclk);
      for (int k = 7; k >= 0; k--)
         tick({3'h0, op[k]}, q);
      for (int k = dio ? 7 : 15; k >= 0; k--)
         tick(dio ? {2'h0, col[2*k+1], col[2*k]} : {3'h0, col[k]}, q);
      repeat (dum) tick(4'h0, q);
      released = 1'b1;
      for (int k = 0; k < n * 8 / ln; k++)
      begin
         tick(4'h0, q);
         b = (ln == 1) ? {b[6:0], q[1]} : (ln == 2) ? {b[5:0], q[1:0]} : {b[3:0], q};
         if ((k + 1) * ln % 8 == 0)
            rx[((k + 1) * ln / 8 - 1) % 16] = b;
      end
      sclk <= 1'b0;
      repeat (8) @(posedge mclk);
      cs_n <= 1'b1;
      repeat (8) @(posedge mclk);
   endtask
endmodule

// *** tb/serial_nand_fast_read_monitor.sv ***
`timescale 1ns/1ps

module serial_nand_fast_read_monitor
(
   // Clock, reset and link pins
   input wire logic        mclk,
   input wire logic        srst,
   input wire logic        cs_n,
   input wire logic [3:0]  io_oe,
   // Configuration and fetch requests
   input wire logic        buf_mode,
   input wire logic [23:0] start_page,
   input wire logic        rd_valid,
   input wire logic        rd_ready,
   input wire logic [23:0] rd_page,
   input wire logic [11:0] rd_col
);
   logic        chained;
   logic [35:0] expect_req;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (srst);

   // Address that the next fetch of a frame must carry
   always_ff @(posedge mclk)
   begin
      chained <= !srst && !cs_n && (chained || (rd_valid && rd_ready));
      if (rd_valid && rd_ready)
         expect_req <= (rd_col == nand_read_pkg::BUF_LAST) ? {rd_page + 24'h1, 12'h0} : {rd_page, rd_col + 12'h1};
   end

   cs_release_a: assert property ($rose(cs_n) |-> ##[1:6] io_oe == 4'h0)
      else $error("outputs on after deselect");
   idle_quiet_a: assert property (cs_n [*8] |-> io_oe == 4'h0)
      else $error("outputs on while deselected");
   lane_mask_a: assert property (io_oe inside {4'h0, 4'h2, 4'h3, 4'hf})
      else $error("illegal output enable mask");
   lane_steady_a: assert property ($changed(io_oe) |-> $past(io_oe) == 4'h0 || io_oe == 4'h0)
      else $error("lane width changed in a frame");
   req_hold_a: assert property (rd_valid && !rd_ready && !cs_n |=> rd_valid && $stable(rd_col) && $stable(rd_page))
      else $error("fetch request dropped");
   req_gap_a: assert property (rd_valid && rd_ready |=> !rd_valid)
      else $error("fetch request without gap");
   addr_step_a: assert property (rd_valid && chained && !cs_n |-> {rd_page, rd_col} == expect_req)
      else $error("fetch address did not step by one");
   seq_origin_a: assert property (rd_valid && !chained && !cs_n && !buf_mode
      |-> rd_col == 12'h0 && rd_page == start_page) else $error("sequential read not from byte zero");
endmodule

bind serial_nand_fast_read serial_nand_fast_read_monitor u_serial_nand_fast_read_monitor
(
   .mclk (mclk), .srst (srst), .cs_n (cs_n), .io_oe (io_oe), .buf_mode (buf_mode), .start_page (start_page),
   .rd_valid (rd_valid), .rd_ready (rd_ready), .rd_page (rd_page), .rd_col (rd_col)
);

// *** tb/serial_nand_fast_read_test.sv ***
`timescale 1ns/1ps

module serial_nand_fast_read_test;
   localparam int BUF_BYTES = nand_read_pkg::BUF_LAST + 1;
   logic        mclk, srst, cs_n, sclk, buf_mode, wp_enable;
   logic        rd_valid, rd_ready, rsp_valid, rsp_ready;
   logic [3:0]  drv, io_in, io_out, io_oe;
   logic [23:0] start_page, rd_page;
   logic [11:0] rd_col, col;
   logic [7:0]  rsp_data;
   logic [35:0] pend [$];
   int          seed = 32'hef7d06bd;
   int          mismatches = 0;
   int          samples_checked = 0;
   int          cycles = 0;
   logic [7:0]  ops [7] = '{nand_read_pkg::OP_FAST, nand_read_pkg::OP_FAST_EXT, nand_read_pkg::OP_DUAL,
      nand_read_pkg::OP_DUAL_EXT, nand_read_pkg::OP_QUAD, nand_read_pkg::OP_QUAD_EXT, nand_read_pkg::OP_DUAL_IO};

   // Each data line carries whoever enables it
   assign io_in = (io_out & io_oe) | (drv & ~io_oe);

   serial_nand_fast_read u_serial_nand_fast_read
   (
      .mclk (mclk), .srst (srst), .cs_n (cs_n), .sclk (sclk), .io_in (io_in), .io_out (io_out), .io_oe (io_oe),
      .buf_mode (buf_mode), .wp_enable (wp_enable), .start_page (start_page), .rd_valid (rd_valid),
      .rd_ready (rd_ready), .rd_page (rd_page), .rd_col (rd_col), .rsp_valid (rsp_valid),
      .rsp_ready (rsp_ready), .rsp_data (rsp_data)
   );
   link_host u_link_host (.mclk (mclk), .cs_n (cs_n), .sclk (sclk), .drv (drv), .io_out (io_out), .io_oe (io_oe));

   function automatic logic [7:0] data_at(logic [23:0] p, logic [11:0] c);
      return p[7:0] ^ c[7:0] ^ {c[11:8], 4'h5};
   endfunction

   function automatic logic [7:0] expect_at(logic bm, logic [23:0] p, logic [11:0] c, int i);
      return bm ? data_at(p, c + 12'(i)) : data_at(p + 24'(i / BUF_BYTES), 12'(i % BUF_BYTES));
   endfunction

   task automatic check_byte(input logic [7:0] exp, input logic [7:0] got);
      samples_checked++;
      if (got !== exp)
      begin
         mismatches++;
         $display("mismatch data byte expected %h seen %h", exp, got);
      end
   endtask

   task automatic check_oe(input logic [3:0] exp, input logic [3:0] got);
      samples_checked++;
      if (got !== exp)
      begin
         mismatches++;
         $display("mismatch output enable expected %h seen %h", exp, got);
      end
   endtask

   // One read with the dummy count and lane width of its opcode
   task automatic run(input int op, input logic bm, input logic [11:0] c, input int n);
      int ln;
      int dum;
      ln  = (op < 2) ? 1 : (op < 4 || op == 6) ? 2 : 4;
      dum = (op == 6) ? (bm ? 4 : 16) : (op % 2) ? (bm ? 24 : 40) : (bm ? 8 : 32);
      buf_mode   <= bm;
      start_page <= 24'($random(seed));
      @(posedge mclk);
      u_link_host.frame(ops[op], {4'h0, c}, dum, n, ln, op == 6);
   endtask

   task automatic check_run(input int first, input int last, input logic [11:0] c);
      for (int i = first; i <= last; i++)
         check_byte(expect_at(buf_mode, start_page, c, i), u_link_host.rx[i % 16]);
   endtask

   task automatic summarize();
      $display("comparisons %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // Data buffer answers fetches in order, accepting at random
   always @(posedge mclk)
   begin
      if (rsp_valid && rsp_ready)
         void'(pend.pop_front());
      if (rd_valid && rd_ready)
         pend.push_back({rd_page, rd_col});
      rd_ready  <= 1'($random(seed));
      rsp_valid <= pend.size() > 0;
      if (pend.size() > 0)
         rsp_data <= data_at(pend[0][35:12], pend[0][11:0]);
   end

   // Clock and hang guard
   initial
   begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end
   always @(posedge mclk)
   begin
      cycles++;
      if (cycles == 95000)
      begin
         mismatches++;
         summarize();
      end
   end

   initial
   begin
      srst       = 1'b1;
      buf_mode   = 1'b1;
      wp_enable  = 1'b0;
      start_page = 24'h0;
      rd_ready   = 1'b0;
      rsp_valid  = 1'b0;
      rsp_data   = 8'h0;
      repeat (10) @(posedge mclk);
      srst <= 1'b0;
      repeat (4) @(posedge mclk);
      for (int k = 0; k < 14; k++)
      begin
         col = 12'($random(seed)) % 12'd2000;
         run(k % 7, k < 7, col, 4);
         check_run(0, 3, col);
      end
      wp_enable <= 1'b1;
      for (int k = 4; k < 6; k++)
      begin
         run(k, 1'b1, 12'h010, 2);
         check_oe(4'h0, u_link_host.oe_any);
      end
      wp_enable <= 1'b0;
      run(0, 1'b1, 12'h87e, 4);
      check_run(0, 1, 12'h87e);
      check_oe(4'h0, u_link_host.oe_last);
      run(4, 1'b0, 12'h0, 2180);
      check_run(2164, 2179, 12'h0);
      summarize();
   end
endmodule
